/* File: wut_pkg.sv */
// Constants, register map and field layout of the wake-up timer
package wut_pkg;

  // Register byte addresses
  localparam logic [31:0] WUT_OFF_LOAD  = 32'hffff0340;
  localparam logic [31:0] WUT_OFF_VALUE = 32'hffff0344;
  localparam logic [31:0] WUT_OFF_CFG   = 32'hffff0348;
  localparam logic [31:0] WUT_OFF_CLR   = 32'hffff034c;
  localparam logic [31:0] WUT_OFF_CAP   = 32'hffff0350;
  localparam logic [31:0] WUT_OFF_STS   = 32'hffff0354;
  localparam logic [31:0] WUT_OFF_MASK  = 32'hffff0358;

  // Reset values
  localparam logic [31:0] WUT_RST_LOAD  = 32'h0;
  localparam logic [31:0] WUT_RST_VALUE = 32'h0;
  localparam logic [10:0] WUT_RST_CFG   = 11'h0;

  // timer_config fields
  localparam int WUT_CFG_W      = 11;
  localparam int WUT_PRE_LSB    = 0;
  localparam int WUT_PRE_MSB    = 3;
  localparam int WUT_FMT_LSB    = 4;
  localparam int WUT_FMT_MSB    = 5;
  localparam int WUT_MODE_BIT   = 6;
  localparam int WUT_EN_BIT     = 7;
  localparam int WUT_DIR_BIT    = 8;
  localparam int WUT_SRC_LSB    = 9;
  localparam int WUT_SRC_MSB    = 10;

  typedef enum logic [1:0] {
    WUT_SRC_OSC  = 2'h0,
    WUT_SRC_CORE = 2'h1,
    WUT_SRC_XTAL = 2'h2,
    WUT_SRC_PLL  = 2'h3
  } wut_src_e;

  typedef enum logic [1:0] {
    WUT_FMT_BIN  = 2'h0,
    WUT_FMT_RSV  = 2'h1,
    WUT_FMT_H23  = 2'h2,
    WUT_FMT_H255 = 2'h3
  } wut_fmt_e;

  // Clock-of-day limits
  localparam logic [7:0] WUT_HUND_MAX = 8'h63;
  localparam logic [7:0] WUT_MS_MAX   = 8'h3b;
  localparam logic [7:0] WUT_H23_MAX  = 8'h17;
  localparam logic [7:0] WUT_H255_MAX = 8'hff;

  // Interrupt status bits and external enable bit
  localparam int WUT_EVT_W      = 2;
  localparam int WUT_STS_OVF    = 0;
  localparam int WUT_STS_CAP    = 1;
  localparam int WUT_INTERRUPT_ENABLE_MASK_BIT  = 4;

  localparam logic [1:0] WUT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] WUT_RESP_SLVERR = 2'h2;

endpackage : wut_pkg

/* File: wut_prescale.sv */
// Clock source selection and power-of-two prescaler, one tick per period
`timescale 1ns/10ps
module wut_prescale
  import wut_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic [1:0] src_sel,
  input  wire logic [3:0] pre_code,
  input  wire logic       osc_32k,
  input  wire logic       xtal_32k,
  input  wire logic       pll_undivided_clock,
  input  wire logic       core_clk_stopped,
  output logic            tick
);

  typedef struct packed {
    logic [2:0]  prev;
    logic [14:0] div;
    logic        tick;
  } wut_pre_s;

  wut_pre_s   s_r;
  wut_pre_s   s_nxt;
  logic       src_edge;
  logic [15:0] mask;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.prev = {pll_undivided_clock, xtal_32k, osc_32k};
    unique case (wut_src_e'(src_sel))                        // RULE3
      WUT_SRC_OSC:  src_edge = osc_32k & ~s_r.prev[0];
      WUT_SRC_CORE: src_edge = ~core_clk_stopped;
      WUT_SRC_XTAL: src_edge = xtal_32k & ~s_r.prev[1];
      WUT_SRC_PLL:  src_edge = pll_undivided_clock & ~s_r.prev[2];
    endcase
    // Divide by two to the power of the code: 0,4,8,15 give 1,16,256,32768
    mask       = (16'h1 << pre_code) - 16'h1;                // RULE4
    s_nxt.tick = enable & src_edge & ((s_r.div & mask[14:0]) == mask[14:0]);
    if (!enable)
    begin
      s_nxt.div = '0;
    end
    else if (src_edge)
    begin
      s_nxt.div = s_r.div + 15'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule : wut_prescale

/* File: wut_timer.sv */
// Wake-up timer with AXI4-Lite register slave and interrupt
// Functional notes
// [RULE1] Counter is 32 bits wide and counts either down or up.
// [RULE2] Config bit 8 picks direction: 1 up, 0 down; down after reset.
// [RULE3] Config bits 10:9 pick the clock: osc, core, crystal, PLL.
// [RULE4] Config bits 3:0 set prescaler: divide by 1, 16, 256, 32768.
// [RULE5] Software should use divide-by-256 with either clock-of-day format.
// [RULE6] Config bit 7 starts or stops counting; stopped after reset.
// [RULE7] Config bit 6 picks periodic (1) or free-running (0) mode.
// [RULE8] Config bits 5:4 pick binary or clock-of-day with 23 or 255 hours.
// [RULE9] Load value enters the counter on overflow in periodic mode and on clear writes.
// [RULE10] Any write to the clear register clears the pending interrupt; the code clears only the overflow status bit, not the capture bit.
// [RULE11] Counting continues while the processor core clock is stopped; with the core clock source selected the code stops counting then.
// [RULE12] Capture works only while enable mask bit 4 is set.
// [RULE13] Value register reads the live count; zero after reset.
// [RULE14] Load register is read/write and zero after reset.
// [RULE15] Config bits 31:11 are reserved and read as zero.
// [RULE16] Passing the terminal value interrupts; periodic reloads, free wraps.
// [RULE17] Clock-of-day rolls hundredths at 100, seconds and minutes at 60.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
module wut_timer
  import wut_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        osc_32k,
  input  wire logic        xtal_32k,
  input  wire logic        pll_undivided_clock,
  input  wire logic        core_clk_stopped,
  input  wire logic        capture_evt,
  input  wire logic [31:0] interrupt_enable_mask,
  output logic             irq
);

  typedef struct packed {
    logic [31:0]          rl;
    logic [WUT_CFG_W-1:0] cfg;
    logic [31:0]          cnt;
    logic [31:0]          cap;
    logic [WUT_EVT_W-1:0] sts;
    logic [WUT_EVT_W-1:0] msk;
    logic                 aw_got;
    logic [31:0]          aw_addr;
    logic                 w_got;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 irq;
  } wut_top_s;

  wut_top_s    s_r;
  wut_top_s    s_nxt;
  logic        tick;
  logic        do_wr;
  logic        clr_wr;
  logic        rd_acc;
  logic        ovf_evt;
  logic        cap_evt;
  logic        run;
  logic        up;
  logic        periodic;
  logic        hms;
  logic        term;
  logic [7:0]  span;
  logic [31:0] step;

  function automatic logic [31:0] wut_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : wut_merge

  // Fields: hours 31:24, minutes 23:16, seconds 15:8, hundredths 7:0
  function automatic logic [31:0] wut_hms_step(
    input logic [31:0] v,
    input logic        cnt_up,
    input logic [7:0]  hmax
  );
    logic [7:0] f   [4];
    logic [7:0] lim [4];
    logic       carry;
    logic       wrap;
    for (int i = 0; i < 4; i++)
    begin
      f[i] = v[i*8 +: 8];
    end
    lim[0] = WUT_HUND_MAX;
    lim[1] = WUT_MS_MAX;
    lim[2] = WUT_MS_MAX;
    lim[3] = hmax;
    carry  = 1'b1;
    // A field steps only when every field below it has wrapped
    for (int i = 0; i < 4; i++)
    begin
      wrap = cnt_up ? (f[i] >= lim[i]) : (f[i] == 8'h0);     // RULE17
      if (carry)
      begin
        f[i] = wrap ? (cnt_up ? 8'h0 : lim[i])
                    : (cnt_up ? f[i] + 8'h1 : f[i] - 8'h1);
      end
      carry = carry & wrap;
    end
    return {f[3], f[2], f[1], f[0]};
  endfunction : wut_hms_step

  // Nothing here looks at the core clock state except the core source itself
  wut_prescale u_prescale (                                    // RULE11
    .clk                 (clk),
    .reset               (reset),
    .enable              (s_r.cfg[WUT_EN_BIT]),
    .src_sel             (s_r.cfg[WUT_SRC_MSB:WUT_SRC_LSB]),
    .pre_code            (s_r.cfg[WUT_PRE_MSB:WUT_PRE_LSB]),
    .osc_32k             (osc_32k),
    .xtal_32k            (xtal_32k),
    .pll_undivided_clock (pll_undivided_clock),
    .core_clk_stopped    (core_clk_stopped),
    .tick                (tick)
  );

  always_comb
  begin
    s_nxt    = s_r;
    run      = s_r.cfg[WUT_EN_BIT];                            // RULE6
    up       = s_r.cfg[WUT_DIR_BIT];                           // RULE2
    periodic = s_r.cfg[WUT_MODE_BIT];                          // RULE7
    // Reserved format 01 counts as plain binary
    hms      = s_r.cfg[WUT_FMT_MSB];                           // RULE8
    span     = s_r.cfg[WUT_FMT_LSB] ? WUT_H255_MAX : WUT_H23_MAX;

    // Write address and data may arrive in either order
    if (s_r.awready && s_axi_awvalid)
    begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_r.wready && s_axi_wvalid)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    do_wr  = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    clr_wr = do_wr && (s_r.aw_addr == WUT_OFF_CLR);
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
    end
    if (do_wr)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = WUT_RESP_OKAY;
      case (s_r.aw_addr)
        WUT_OFF_LOAD:
          s_nxt.rl = wut_merge(s_r.rl, s_r.wdata, s_r.wstrb);  // RULE14
        WUT_OFF_CFG:
          s_nxt.cfg = WUT_CFG_W'(wut_merge({21'h0, s_r.cfg}, s_r.wdata,
                                           s_r.wstrb));        // RULE15
        WUT_OFF_MASK:
          s_nxt.msk = WUT_EVT_W'(wut_merge({30'h0, s_r.msk}, s_r.wdata,
                                           s_r.wstrb));
        // Read-only words take the write and ignore it; clear acts through clr_wr
        WUT_OFF_CLR, WUT_OFF_VALUE, WUT_OFF_CAP, WUT_OFF_STS: ;
        default:
          s_nxt.bresp = WUT_RESP_SLVERR;
      endcase
    end

    // Read channel
    rd_acc = s_r.arready && s_axi_arvalid;
    if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (rd_acc)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = WUT_RESP_OKAY;
      s_nxt.rdata  = 32'h0;
      case (s_axi_araddr)
        WUT_OFF_LOAD:  s_nxt.rdata = s_r.rl;
        WUT_OFF_VALUE: s_nxt.rdata = s_r.cnt;                  // RULE13
        WUT_OFF_CFG:   s_nxt.rdata = {21'h0, s_r.cfg};         // RULE15
        WUT_OFF_CAP:   s_nxt.rdata = s_r.cap;
        WUT_OFF_STS:   s_nxt.rdata = {30'h0, s_r.sts};
        WUT_OFF_MASK:  s_nxt.rdata = {30'h0, s_r.msk};
        WUT_OFF_CLR:   s_nxt.rdata = 32'h0;
        default:       s_nxt.rresp = WUT_RESP_SLVERR;
      endcase
    end

    // Counter
    if (up)
    begin
      term = hms ? (s_r.cnt == {span, WUT_MS_MAX, WUT_MS_MAX, WUT_HUND_MAX})
                 : (&s_r.cnt);
    end
    else
    begin
      term = (s_r.cnt == 32'h0);
    end
    if (hms)
    begin
      step = wut_hms_step(s_r.cnt, up, span);                  // RULE17
    end
    else
    begin
      step = up ? s_r.cnt + 32'h1 : s_r.cnt - 32'h1;           // RULE1
    end
    ovf_evt = run && tick && term && !clr_wr;                  // RULE16
    if (clr_wr)
    begin
      s_nxt.cnt = s_r.rl;                                      // RULE9
    end
    else if (run && tick)
    begin
      s_nxt.cnt = (term && periodic) ? s_r.rl : step;          // RULE16
    end

    // Capture the live count on an event while the enable bit allows it
    cap_evt = capture_evt && interrupt_enable_mask[WUT_INTERRUPT_ENABLE_MASK_BIT]; // RULE12
    if (cap_evt)
    begin
      s_nxt.cap = s_r.cnt;
    end

    // Clears first so that an event in the same cycle survives
    if (rd_acc && s_axi_araddr == WUT_OFF_STS)
    begin
      s_nxt.sts = '0;
    end
    if (clr_wr)
    begin
      s_nxt.sts[WUT_STS_OVF] = 1'b0;                           // RULE10
    end
    if (ovf_evt)
    begin
      s_nxt.sts[WUT_STS_OVF] = 1'b1;
    end
    if (cap_evt)
    begin
      s_nxt.sts[WUT_STS_CAP] = 1'b1;
    end

    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
    s_nxt.irq     = |(s_nxt.sts & s_nxt.msk);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r         <= '0;
      s_r.rl      <= WUT_RST_LOAD;
      s_r.cnt     <= WUT_RST_VALUE;
      s_r.cfg     <= WUT_RST_CFG;
      s_r.awready <= 1'b1;
      s_r.wready  <= 1'b1;
      s_r.arready <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign irq           = s_r.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_clear_reload: assert property ( // RULE9
    clr_wr |=> s_r.cnt == $past(s_r.rl))
    else $error("clear write did not reload the counter");
  a_clear_irq: assert property ( // RULE10
    clr_wr && !cap_evt && !s_r.msk[WUT_STS_CAP] |=> !irq)
    else $error("clear write left the overflow interrupt raised");
  a_stop_hold: assert property (!run && !clr_wr |=> $stable(s_r.cnt)) // RULE6
    else $error("stopped counter moved");
  a_down_step: assert property (run && tick && !up && !hms // RULE2
    && !term && !clr_wr |=> s_r.cnt == $past(s_r.cnt) - 32'h1)
    else $error("down count step wrong");
  a_up_step: assert property (run && tick && up && !hms // RULE1
    && !term && !clr_wr |=> s_r.cnt == $past(s_r.cnt) + 32'h1)
    else $error("up count step wrong");
  a_period_reload: assert property (ovf_evt && periodic // RULE16
    |=> s_r.cnt == $past(s_r.rl) && s_r.sts[WUT_STS_OVF])
    else $error("terminal count did not reload and flag");
  a_capture_gate: assert property ( // RULE12
    !interrupt_enable_mask[WUT_INTERRUPT_ENABLE_MASK_BIT] |=> $stable(s_r.cap))
    else $error("capture taken while interrupt disabled");
  a_cfg_reserved: assert property (s_axi_rvalid // RULE15
    |-> !(s_r.rdata[31:WUT_CFG_W] != 21'h0 && $past(rd_acc)
    && $past(s_axi_araddr) == WUT_OFF_CFG))
    else $error("reserved config bits read nonzero");
  a_irq_level: assert property ( // RULE16
    ovf_evt && s_r.msk[WUT_STS_OVF] && !do_wr |=> irq)
    else $error("unmasked overflow left the interrupt low");

endmodule : wut_timer

/* File: wut_timer_tb.sv */
// Self-checking testbench for the wake-up timer
`timescale 1ns/10ps
module testbench
  import wut_pkg::*;
;
  logic        clk, reset, awv, wv, bready, arv, rready;
  logic        osc, xtal, pll, cstop, cap;
  logic [31:0] awaddr, wdata, araddr, emask, rd;
  logic [3:0]  wstrb;
  logic [1:0]  rs;
  wire         awready, wready, bvalid, arready, rvalid, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          miscompares, check_count;

  wut_timer i_wut_timer (
    .clk(clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .osc_32k(osc),
    .xtal_32k(xtal), .pll_undivided_clock(pll), .core_clk_stopped(cstop),
    .capture_evt(cap), .interrupt_enable_mask(emask), .irq(irq)
  );

  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task check(string n, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : check

  // Address and data leave together; each is dropped once taken
  task wr(logic [31:0] a, logic [31:0] d, logic [3:0] s = 4'hf);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    forever
    begin
      @(posedge clk);
      if (awv && awready) awv <= 0;
      if (wv && wready) wv <= 0;
      if (bvalid && bready)
      begin
        rs = bresp;
        bready <= 0;
        break;
      end
    end
  endtask : wr

  task rr(logic [31:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    forever
    begin
      @(posedge clk);
      if (arv && arready) arv <= 0;
      if (rvalid && rready)
      begin
        rd = rdata;
        rs = rresp;
        rready <= 0;
        break;
      end
    end
  endtask : rr

  task rc(string n, logic [31:0] a, logic [31:0] exp);
    rr(a);
    check(n, rd, exp);
  endtask : rc

  // irq is registered, so give it a few edges to settle
  task ci(logic exp);
    repeat (3) @(posedge clk);
    #1 check("irq", irq, exp);
  endtask : ci

  // One source tick is a high cycle followed by a low cycle
  task tk(logic [1:0] s, int n);
    repeat (n)
    begin
      @(posedge clk);
      osc <= (s == 2'h0);
      xtal <= (s == 2'h2);
      pll <= (s == 2'h3);
      @(posedge clk);
      osc <= 0;
      xtal <= 0;
      pll <= 0;
    end
    repeat (4) @(posedge clk);
  endtask : tk

  // Stop, load, reload through the clear register, then start
  task go(logic [31:0] ld, logic [31:0] c);
    wr(WUT_OFF_CFG, c & 32'hffffff7f);
    wr(WUT_OFF_LOAD, ld);
    wr(WUT_OFF_CLR, 32'h0);
    wr(WUT_OFF_CFG, c);
  endtask : go

  task t_reset;
    rc("load", WUT_OFF_LOAD, 32'h0);
    rc("count", WUT_OFF_VALUE, 32'h0);
    rc("config", WUT_OFF_CFG, 32'h0);
    ci(0);
  endtask : t_reset

  task t_regs;
    wr(WUT_OFF_CFG, 32'hffffffff);
    rc("config", WUT_OFF_CFG, 32'h7ff);
    wr(WUT_OFF_CFG, 32'h0);
    wr(WUT_OFF_LOAD, 32'h12345678);
    wr(WUT_OFF_LOAD, 32'h0000aa00, 4'h2);
    rc("load", WUT_OFF_LOAD, 32'h1234aa78);
    wr(WUT_OFF_VALUE, 32'h5);
    check("ro wresp", rs, WUT_RESP_OKAY);
    rc("count", WUT_OFF_VALUE, 32'h0);
    rc("clear", WUT_OFF_CLR, 32'h0);
    check("read resp", rs, WUT_RESP_OKAY);
    rc("unmapped", 32'hffff0360, 32'h0);
    check("unmapped resp", rs, WUT_RESP_SLVERR);
    wr(32'hffff0360, 32'h1);
    check("unmapped wresp", rs, WUT_RESP_SLVERR);
  endtask : t_regs

  // Ticks from the oscillator still count with the core clock stopped
  task t_count;
    cstop <= 1;
    go(32'h5, 32'h080);
    rc("count", WUT_OFF_VALUE, 32'h5);
    tk(2'h0, 3);
    rc("count", WUT_OFF_VALUE, 32'h2);
    wr(WUT_OFF_CFG, 32'h0);
    tk(2'h0, 2);
    rc("count", WUT_OFF_VALUE, 32'h2);
    cstop <= 0;
  endtask : t_count

  task automatic t_sources;
    logic [1:0] sv [3] = '{2'h0, 2'h2, 2'h3};
    foreach (sv[i])
    begin
      go(32'h5, {21'h0, sv[i], 9'h080});
      tk(sv[i] == 2'h0 ? 2'h2 : 2'h0, 2);
      tk(sv[i], 1);
      rc("source", WUT_OFF_VALUE, 32'h4);
    end
    go(32'd100, 32'h280);
    repeat (10) @(posedge clk);
    wr(WUT_OFF_CFG, 32'h0);
    rr(WUT_OFF_VALUE);
    check("core source", rd < 32'd100 && rd > 32'd80, 32'h1);
  endtask : t_sources

  task t_prescale;
    go(32'h7, 32'h084);
    tk(2'h0, 16);
    rc("div16", WUT_OFF_VALUE, 32'h6);
    tk(2'h0, 16);
    rc("div16", WUT_OFF_VALUE, 32'h5);
    go(32'h7, 32'h28f);
    repeat (40000) @(posedge clk);
    wr(WUT_OFF_CFG, 32'h0);
    rr(WUT_OFF_VALUE);
    check("div32768", rd == 32'h6 || rd == 32'h5, 32'h1);
  endtask : t_prescale

  // Terminal, wrap, reload, clock-of-day and reserved format from one table;
  // clock-of-day rows keep to divide-by-256 as software is told to
  task automatic t_table;
    logic [31:0] tl [9] = '{32'h1, 32'hfffffffe, 32'hfffffffe, 32'h3,
      32'h3b62, 32'h173b3b63, 32'h173b3b63, 32'h01000000, 32'h5};
    logic [31:0] tc [9] = '{32'h080, 32'h180, 32'h1c0, 32'h0c0,
      32'h1a8, 32'h1a8, 32'h1b8, 32'h0a8, 32'h090};
    int          tn [9] = '{2, 2, 2, 4, 512, 256, 256, 256, 1};
    logic [31:0] te [9] = '{32'hffffffff, 32'h0, 32'hfffffffe, 32'h3,
      32'h00010000, 32'h0, 32'h18000000, 32'h003b3b63, 32'h4};
    logic        ti [9] = '{1, 1, 1, 1, 0, 1, 0, 0, 0};
    wr(WUT_OFF_MASK, 32'h1);
    foreach (tl[i])
    begin
      go(tl[i], tc[i]);
      tk(2'h0, tn[i]);
      rc("count", WUT_OFF_VALUE, te[i]);
      ci(ti[i]);
    end
  endtask : t_table

  task t_irq;
    go(32'h3, 32'h0c0);
    tk(2'h0, 4);
    ci(1);
    wr(WUT_OFF_LOAD, 32'h9);
    wr(WUT_OFF_CLR, 32'h5a);
    ci(0);
    rc("count", WUT_OFF_VALUE, 32'h9);
    wr(WUT_OFF_MASK, 32'h0);
    go(32'h0, 32'h080);
    tk(2'h0, 1);
    ci(0);
    rr(WUT_OFF_STS);
    check("status", rd, 32'h1);
    rc("status", WUT_OFF_STS, 32'h0);
  endtask : t_irq

  task t_capture;
    wr(WUT_OFF_MASK, 32'h2);
    go(32'h5, 32'h080);
    repeat (2)
    begin
      @(posedge clk);
      cap <= 1;
      @(posedge clk);
      cap <= 0;
      ci(emask[4]);
      rc("capture", WUT_OFF_CAP, emask[4] ? 32'h5 : 32'h0);
      emask <= 32'h10;
    end
    rc("status", WUT_OFF_STS, 32'h2);
  endtask : t_capture

  task summarize;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (80000) @(posedge clk);
    miscompares++;
    summarize;
  end

  initial
  begin
    {awv, wv, bready, arv, rready, osc, xtal, pll, cstop, cap} = '0;
    {awaddr, wdata, araddr, emask} = '0;
    wstrb = 4'h0;
    reset = 1;
    repeat (16) @(posedge clk);
    reset <= 0;
    t_reset;
    t_regs;
    t_count;
    t_sources;
    t_prescale;
    t_table;
    t_irq;
    t_capture;
    summarize;
  end
endmodule : testbench
